//--- general_purpose_timer.sv
// General-purpose timer: prescaler, auto-reload counter, up to four channels, events
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
module general_purpose_timer
  import gp_timer_pkg::*;
#(
  parameter logic [1:0] VARIANT = VAR_FULL
)
(
  input wire logic clk,
  input wire logic resetn,
  input bus_req_t bus,
  output logic [31:0] rdata,
  input wire logic [3:0] ch_in,
  input wire logic dbg_halt,
  input wire logic trig_in,
  output logic [3:0] ch_out,
  output logic irq,
  output logic dma_req,
  output logic trig_out
);

  localparam logic [31:0] WMASK = width_mask(VARIANT);
  localparam logic [3:0] CHMASK = chan_mask(VARIANT);
  localparam logic HAS_DMA = (VARIANT == VAR_FULL) || (VARIANT == VAR_WIDE);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] psc;
    logic [15:0] psc_cnt;
    logic [31:0] arr;
    logic [31:0] cnt;
    dir_t dir;
    logic [7:0] chmode;
    logic [3:0][31:0] ccr;
    logic [5:0] status;
    logic [5:0] mask;
    logic [5:0] dmaen;
    logic [3:0] in_prev;
    logic [3:0] out;
    logic trig_prev;
    logic irq;
    logic dma_req;
    logic trig_out;
    logic [31:0] rdata;
  } st_t;

  localparam st_t RST_ST = '{arr: RST_ARR, dir: DIR_UP, default: '0};

  st_t s_r;
  st_t s_nxt;
  quad_t qd;
  logic [1:0] mode;
  logic [1:0] slave;
  logic trig_rise;
  logic run;
  logic tick;
  logic going_up;
  logic upd;
  logic [3:0] ch_eff;
  logic [3:0] ccev;
  logic [5:0] ev;
  logic [31:0] rd;

  // Encoder phases come from channel inputs 0 and 1
  quad_decoder u_quad (
    .clk(clk),
    .resetn(resetn),
    .phase_a(ch_in[0]),
    .phase_b(ch_in[1]),
    .q(qd)
  );

  // Next state: prescale, count, channels, flags, register access
  always_comb begin
    s_nxt = s_r;
    mode = (VARIANT == VAR_SINGLE) ? CM_UP : s_r.ctrl[CTRL_MODE +: 2];
    slave = s_r.ctrl[CTRL_SLV +: 2];
    trig_rise = trig_in & ~s_r.trig_prev;
    s_nxt.trig_prev = trig_in;
    run = s_r.ctrl[CTRL_EN] & ~(s_r.ctrl[CTRL_FRZ] & dbg_halt);
    tick = 1'b0;
    upd = 1'b0;
    ccev = 4'h0;
    ch_eff = 4'h0;
    rd = 32'h0;

    // Prescaler: a tick every psc+1 source events, but one per encoder step unscaled; a count above a lowered limit ends at once
    if (run && slave == SL_ENC) begin
      tick = qd.step;
    end else if (run && (slave != SL_EXT || trig_rise)) begin
      if (s_r.psc_cnt >= s_r.psc) begin
        s_nxt.psc_cnt = 16'h0;
        tick = 1'b1;
      end else begin
        s_nxt.psc_cnt = s_r.psc_cnt + 16'h1;
      end
    end

    // Direction of the next step
    if (slave == SL_ENC) begin
      going_up = qd.up;
    end else begin
      going_up = (mode == CM_UP) || (mode == CM_CENTER && s_r.dir == DIR_UP);
    end

    // Counter with auto-reload and update event
    if (run && slave == SL_RST && trig_rise) begin
      s_nxt.cnt = 32'h0;
      s_nxt.psc_cnt = 16'h0;
      upd = 1'b1;
    end else if (tick) begin
      if (going_up) begin
        if (s_r.cnt == s_r.arr) begin
          upd = 1'b1;
          if (mode == CM_CENTER && slave != SL_ENC) begin
            s_nxt.dir = DIR_DOWN;
            s_nxt.cnt = (s_r.arr - 32'h1) & WMASK;
          end else begin
            s_nxt.cnt = 32'h0;
          end
        end else begin
          s_nxt.cnt = (s_r.cnt + 32'h1) & WMASK;
        end
      end else begin
        if (s_r.cnt == 32'h0) begin
          upd = 1'b1;
          if (mode == CM_CENTER && slave != SL_ENC) begin
            s_nxt.dir = DIR_UP;
            s_nxt.cnt = 32'h1 & WMASK;
          end else begin
            s_nxt.cnt = s_r.arr & WMASK;
          end
        end else begin
          s_nxt.cnt = (s_r.cnt - 32'h1) & WMASK;
        end
      end
    end

    // One-pulse: stop at the update event
    if (upd && s_r.ctrl[CTRL_OPM]) begin
      s_nxt.ctrl[CTRL_EN] = 1'b0;
    end

    // Channels; absent channels stay idle and low
    for (int i = 0; i < 4; i++) begin
      ch_eff[i] = (i == 0 && s_r.ctrl[CTRL_HALL]) ? ^ch_in[2:0] : ch_in[i];
      if (CHMASK[i]) begin
        s_nxt.in_prev[i] = ch_eff[i];
        case (s_r.chmode[2*i +: 2])
          CH_CAPT: begin
            if (ch_eff[i] && !s_r.in_prev[i]) begin
              s_nxt.ccr[i] = s_r.cnt;
              ccev[i] = 1'b1;
            end
          end
          CH_TOGGLE: begin
            if (tick && s_nxt.cnt == s_r.ccr[i]) begin
              s_nxt.out[i] = ~s_r.out[i];
              ccev[i] = 1'b1;
            end
          end
          CH_PWM: begin
            s_nxt.out[i] = s_nxt.cnt < s_r.ccr[i];
            ccev[i] = tick && s_nxt.cnt == s_r.ccr[i];
          end
          CH_SET: begin
            if (upd) begin
              s_nxt.out[i] = 1'b0;
            end
            if (tick && s_nxt.cnt == s_r.ccr[i]) begin
              s_nxt.out[i] = 1'b1;
              ccev[i] = 1'b1;
            end
          end
          default: begin
            s_nxt.out[i] = 1'b0;
          end
        endcase
      end
    end

    ev = {trig_rise, ccev, upd};

    // Software writes; a counter write wins over counting
    if (bus.we) begin
      case (bus.addr)
        A_CTRL: s_nxt.ctrl = bus.wdata[7:0];
        A_PSC: s_nxt.psc = bus.wdata[15:0];
        A_ARR: s_nxt.arr = bus.wdata & WMASK;
        A_CNT: s_nxt.cnt = bus.wdata & WMASK;
        A_CHMODE: s_nxt.chmode = bus.wdata[7:0];
        A_MASK: s_nxt.mask = bus.wdata[5:0];
        A_DMAEN: s_nxt.dmaen = HAS_DMA ? bus.wdata[5:0] : 6'h0;
        default: begin
        end
      endcase
      for (int i = 0; i < 4; i++) begin
        if (CHMASK[i] && bus.addr == ccr_addr(i)) begin
          s_nxt.ccr[i] = bus.wdata & WMASK;
        end
      end
    end

    // Sticky flags: write one clears, a new event wins
    s_nxt.status = s_r.status & ~((bus.we && bus.addr == A_STATUS) ? bus.wdata[5:0] : 6'h0);
    s_nxt.status = s_nxt.status | ev;

    // Read mux, data valid only the cycle after the strobe
    case (bus.addr)
      A_CTRL: rd = {24'h0, s_r.ctrl};
      A_PSC: rd = {16'h0, s_r.psc};
      A_ARR: rd = s_r.arr;
      A_CNT: rd = s_r.cnt;
      A_CHMODE: rd = {24'h0, s_r.chmode};
      A_STATUS: rd = {26'h0, s_r.status};
      A_MASK: rd = {26'h0, s_r.mask};
      A_DMAEN: rd = {26'h0, s_r.dmaen};
      default: rd = 32'h0;
    endcase
    for (int i = 0; i < 4; i++) begin
      if (CHMASK[i] && bus.addr == ccr_addr(i)) begin
        rd = s_r.ccr[i];
      end
    end
    s_nxt.rdata = bus.re ? rd : 32'h0;

    // Outputs
    s_nxt.irq = |(s_nxt.status & s_nxt.mask);
    s_nxt.dma_req = HAS_DMA && |(ev & s_r.dmaen);
    s_nxt.trig_out = upd;
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= RST_ST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // One single-ended output per channel, no complementary pair
  assign ch_out = s_r.out;
  assign irq = s_r.irq;
  assign dma_req = s_r.dma_req;
  assign trig_out = s_r.trig_out;
  assign rdata = s_r.rdata;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_up_limit;
    tick && going_up && mode == CM_UP && slave == SL_INT && s_r.cnt == s_r.arr && !bus.we;
  endsequence

  sequence s_wrapped;
    s_r.cnt == 32'h0 && s_r.status[ST_UPD] && s_r.trig_out;
  endsequence

  a_up_wrap: assert property (s_up_limit |=> s_wrapped)
    else $error("Up count did not wrap to zero with update");

  a_down_reload: assert property (tick && !going_up && slave == SL_INT && mode == CM_DOWN
      && s_r.cnt == 32'h0 && !bus.we |=> s_r.cnt == $past(s_r.arr))
    else $error("Down count did not reload");

  a_width_mask: assert property ((s_r.cnt & ~WMASK) == 32'h0)
    else $error("Counter exceeds its width");

  a_presc_div: assert property (run && slave == SL_INT && s_r.psc_cnt == s_r.psc && !bus.we
      |-> tick ##1 s_r.psc_cnt == 16'h0)
    else $error("Prescaler did not tick at its limit");

  a_capture_value: assert property (s_r.chmode[1:0] == CH_CAPT && ch_eff[0] && !s_r.in_prev[0]
      && !bus.we |=> s_r.ccr[0] == $past(s_r.cnt) && s_r.status[ST_CC])
    else $error("Capture missed the counter value");

  a_debug_freeze: assert property (s_r.ctrl[CTRL_FRZ] && dbg_halt && slave != SL_RST && !bus.we
      |=> $stable(s_r.cnt))
    else $error("Counter moved during debug halt");

  a_dma_gate: assert property (dma_req |-> HAS_DMA && $past(|(ev & s_r.dmaen)))
    else $error("DMA request without enabled event");

  a_encoder_step: assert property (run && slave == SL_ENC && qd.step && qd.up
      && s_r.cnt != s_r.arr && !bus.we |=> s_r.cnt == (($past(s_r.cnt) + 32'h1) & WMASK))
    else $error("Encoder step did not advance counter");

  a_hall_capture: assert property (s_r.ctrl[CTRL_HALL] && s_r.chmode[1:0] == CH_CAPT
      && (^ch_in[2:0]) && !s_r.in_prev[0] |=> s_r.status[ST_CC])
    else $error("Hall change not captured");

  a_trig_chain: assert property (upd |=> trig_out ##1 (!trig_out || $past(upd)))
    else $error("Trigger out does not follow update");

  a_absent_chan: assert property ((ch_out & ~CHMASK) == 4'h0 && (s_r.ccr[3] == 32'h0 || CHMASK[3]))
    else $error("Absent channel is active");

  a_single_up: assert property (VARIANT == VAR_SINGLE && tick && slave != SL_ENC |-> going_up)
    else $error("Single-channel variant counted down");

  a_update_irq: assert property (irq == |(s_r.status & s_r.mask))
    else $error("Interrupt does not match flags and mask");

endmodule : general_purpose_timer

//--- gp_timer_pkg.sv
// Constants, codes and carrier types shared by the timer and its encoder decoder
package gp_timer_pkg;

  // Register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PSC = 8'h04;
  localparam logic [7:0] A_ARR = 8'h08;
  localparam logic [7:0] A_CNT = 8'h0c;
  localparam logic [7:0] A_CHMODE = 8'h10;
  localparam logic [7:0] A_CCR0 = 8'h14;
  localparam logic [7:0] A_STATUS = 8'h24;
  localparam logic [7:0] A_MASK = 8'h28;
  localparam logic [7:0] A_DMAEN = 8'h2c;

  // Control register field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_OPM = 3;
  localparam int CTRL_FRZ = 4;
  localparam int CTRL_SLV = 5;
  localparam int CTRL_HALL = 7;

  // Status, mask and DMA enable bit positions
  localparam int ST_UPD = 0;
  localparam int ST_CC = 1;
  localparam int ST_TRG = 5;

  // Count modes
  localparam logic [1:0] CM_UP = 2'h0;
  localparam logic [1:0] CM_DOWN = 2'h1;
  localparam logic [1:0] CM_CENTER = 2'h2;

  // Count source modes
  localparam logic [1:0] SL_INT = 2'h0;
  localparam logic [1:0] SL_ENC = 2'h1;
  localparam logic [1:0] SL_RST = 2'h2;
  localparam logic [1:0] SL_EXT = 2'h3;

  // Channel modes
  localparam logic [1:0] CH_CAPT = 2'h0;
  localparam logic [1:0] CH_TOGGLE = 2'h1;
  localparam logic [1:0] CH_PWM = 2'h2;
  localparam logic [1:0] CH_SET = 2'h3;

  // Variants
  localparam logic [1:0] VAR_FULL = 2'h0;
  localparam logic [1:0] VAR_WIDE = 2'h1;
  localparam logic [1:0] VAR_DUAL = 2'h2;
  localparam logic [1:0] VAR_SINGLE = 2'h3;

  // Reset value and counter width masks
  localparam logic [31:0] RST_ARR = 32'h0000_ffff;
  localparam logic [31:0] MASK16 = 32'h0000_ffff;
  localparam logic [31:0] MASK32 = 32'hffff_ffff;

  // Counting direction state
  typedef enum logic [1:0] {DIR_UP = 2'b01, DIR_DOWN = 2'b10} dir_t;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } bus_req_t;

  // Decoded encoder step
  typedef struct packed {
    logic step;
    logic up;
  } quad_t;

  // Counter width mask of a variant
  function automatic logic [31:0] width_mask(input logic [1:0] v);
    return (v == VAR_WIDE) ? MASK32 : MASK16;
  endfunction : width_mask

  // Present channels of a variant
  function automatic logic [3:0] chan_mask(input logic [1:0] v);
    case (v)
      VAR_DUAL: return 4'h3;
      VAR_SINGLE: return 4'h1;
      default: return 4'hf;
    endcase
  endfunction : chan_mask

  // Byte address of a channel compare register
  function automatic logic [7:0] ccr_addr(input int i);
    return A_CCR0 + 8'(i * 4);
  endfunction : ccr_addr

endpackage : gp_timer_pkg

//--- quad_decoder.sv
// Quadrature encoder decoder: one step per edge of either phase
module quad_decoder
  import gp_timer_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic phase_a,
  input wire logic phase_b,
  output quad_t q
);

  typedef struct packed {
    logic a_prev;
    logic b_prev;
    quad_t q;
  } qstate_t;

  qstate_t s_r;
  qstate_t s_nxt;

  // Edge on either phase is a step; phase order gives direction
  always_comb begin
    s_nxt = s_r;
    s_nxt.a_prev = phase_a;
    s_nxt.b_prev = phase_b;
    s_nxt.q.step = (phase_a ^ s_r.a_prev) | (phase_b ^ s_r.b_prev);
    s_nxt.q.up = s_r.a_prev ^ phase_b;
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.q;

endmodule : quad_decoder

//--- pin_partner.sv
// External pin model: quadrature encoder phases and a sibling timer trigger
module pin_partner (
  input wire logic clk,
  input wire logic resetn,
  input wire logic step_req,
  input wire logic step_fwd,
  input wire logic trig_req,
  output logic [1:0] phases,
  output logic trig
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] pos_r;
  logic [1:0] tcnt_r;
  // One encoder edge per request; the trigger stands three cycles
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pos_r <= 2'h0;
      tcnt_r <= 2'h0;
    end else begin
      if (step_req) begin
        pos_r <= step_fwd ? pos_r + 2'h1 : pos_r - 2'h1;
      end
      if (trig_req) begin
        tcnt_r <= 2'h3;
      end else if (tcnt_r != 2'h0) begin
        tcnt_r <= tcnt_r - 2'h1;
      end
    end
  end
  // Gray coding keeps the two phases from moving together
  assign phases = {pos_r[1], pos_r[1] ^ pos_r[0]};
  assign trig = (tcnt_r != 2'h0);
endmodule : pin_partner

//--- testbench.sv
// Self-checking bench for the general-purpose timer
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import gp_timer_pkg::*;
  logic clk, resetn, dbg_halt, step_req, step_fwd, trig_req, trig_in, irq, dma_req, trig_out;
  logic [1:0] phases, pins_r;
  logic [3:0] ch_out;
  logic [31:0] rdata, d, e;
  bus_req_t bus;
  int seed = 32'h21462890;
  int error_cnt = 0;
  int checks = 0;
  int n, psc, arr, m, n1, n2;

  general_purpose_timer u_general_purpose_timer (.clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata),
    .ch_in({pins_r, phases}), .dbg_halt(dbg_halt), .trig_in(trig_in), .ch_out(ch_out), .irq(irq),
    .dma_req(dma_req), .trig_out(trig_out));
  pin_partner u_pin_partner (.clk(clk), .resetn(resetn), .step_req(step_req), .step_fwd(step_fwd),
    .trig_req(trig_req), .phases(phases), .trig(trig_in));

  // Free-running clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("Counts: %0d checks, %0d mismatches", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  // One-cycle write and read strobes; read data stand the cycle after
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
    @(posedge clk);
    bus.we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
    @(posedge clk);
    bus.re <= 1'b0;
    #1;
    v = rdata;
  endtask : rd

  task automatic start(input logic [31:0] ctrl, input logic [31:0] p, input logic [31:0] a);
    wr(A_CTRL, 32'h0);
    wr(A_CNT, 32'h0);
    wr(A_PSC, p);
    wr(A_ARR, a);
    wr(A_CTRL, ctrl);
  endtask : start

  // Cycles from the present update pulse to the next, bounded
  task automatic wait_trig(output int k);
    k = 0;
    @(posedge clk);
    #1;
    while (trig_out !== 1'b1) begin
      if (k > 5000) begin
        error_cnt++;
        conclude();
      end
      @(posedge clk);
      #1;
      k++;
    end
  endtask : wait_trig

  task automatic step(input int k, input logic fwd);
    repeat (k) begin
      @(posedge clk);
      step_req <= 1'b1;
      step_fwd <= fwd;
      @(posedge clk);
      step_req <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : step

  // Update period: a full sweep, or one leg when counting up and down
  function automatic int period(input int mode, input int p, input int a);
    return (mode == CM_CENTER) ? a * (p + 1) : (a + 1) * (p + 1);
  endfunction : period

  initial begin
    resetn = 1'b0;
    bus = '0;
    dbg_halt = 1'b0;
    step_req = 1'b0;
    step_fwd = 1'b0;
    trig_req = 1'b0;
    pins_r = 2'h0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(A_ARR, d);
    check(d, RST_ARR, "arr reset");
    rd(A_CNT, d);
    check(d, 32'h0, "cnt reset");
    rd(8'h3c, d);
    check(d, 32'h0, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      e = $random(seed) & 32'hffff;
      wr(ccr_addr(i), e);
      rd(ccr_addr(i), d);
      check(d, e, "ccr readback");
    end
    $display("test registers done");
    pins_r <= 2'($random(seed));
    for (m = 0; m < 3; m++) begin
      psc = (m == 0) ? 0 : ($random(seed) & 3);
      arr = 3 + ($random(seed) & 3);
      start(32'(1 | (m << CTRL_MODE)), 32'(psc), 32'(arr));
      repeat (3) wait_trig(n);
      check(32'(n + 1), 32'(period(m, psc, arr)), "update period");
    end
    wr(A_CTRL, 32'h0);
    rd(A_STATUS, d);
    check(32'(d[ST_UPD]), 32'h1, "update flag");
    check(32'(irq), 32'h0, "irq masked");
    wr(A_MASK, 32'h1 << ST_UPD);
    @(posedge clk);
    #1;
    check(32'(irq), 32'h1, "irq unmasked");
    wr(A_STATUS, 32'h1 << ST_UPD);
    @(posedge clk);
    #1;
    check(32'(irq), 32'h0, "irq cleared");
    $display("test counting done");
    wr(A_DMAEN, 32'h1 << ST_UPD);
    start(32'h1, 32'h0, 32'h3);
    wait_trig(n);
    check(32'(dma_req), 32'h1, "dma with update");
    wr(A_DMAEN, 32'h0);
    wait_trig(n);
    check(32'(dma_req), 32'h0, "dma disabled");
    wr(ccr_addr(0), 32'h4);
    wr(ccr_addr(1), 32'h6);
    wr(ccr_addr(2), 32'h3);
    wr(A_CHMODE, 32'(CH_PWM) | (32'(CH_SET) << 2) | (32'(CH_TOGGLE) << 4));
    start(32'h1, 32'h0, 32'h9);
    repeat (20) @(posedge clk);
    n = 0;
    n1 = 0;
    n2 = 0;
    repeat (100) begin
      @(posedge clk);
      #1;
      n += int'(ch_out[0]);
      n1 += int'(ch_out[1]);
      n2 += int'(ch_out[2]);
    end
    check(32'(n), 32'd40, "pwm duty");
    check(32'(n1), 32'd40, "set on match duty");
    check(32'(n2), 32'd50, "toggle duty");
    $display("test dma and pwm done");
    start(32'(1 | (1 << CTRL_FRZ)), 32'h0, 32'hffff);
    dbg_halt <= 1'b1;
    repeat (3) @(posedge clk);
    rd(A_CNT, d);
    repeat (10) @(posedge clk);
    rd(A_CNT, e);
    check(e, d, "frozen count");
    dbg_halt <= 1'b0;
    repeat (10) @(posedge clk);
    rd(A_CNT, e);
    check(32'(e != d), 32'h1, "resumed count");
    $display("test freeze done");
    start(32'(1 | (32'(SL_ENC) << CTRL_SLV)), 32'h0, 32'hffff);
    wr(A_CNT, 32'h10);
    n = 4 + ($random(seed) & 7);
    step(n, 1'b1);
    rd(A_CNT, d);
    d = d - 32'h10;
    check(32'((d[15:0] == 16'(n)) || (d[15:0] == 16'(-n))), 32'h1, "encoder count");
    step(n, 1'b0);
    rd(A_CNT, d);
    check(d, 32'h10, "encoder return");
    $display("test encoder done");
    wr(A_STATUS, 32'h3f);
    start(32'(1 | (32'(SL_RST) << CTRL_SLV)), 32'h0, 32'hffff);
    repeat (50) @(posedge clk);
    trig_req <= 1'b1;
    @(posedge clk);
    trig_req <= 1'b0;
    repeat (4) @(posedge clk);
    rd(A_CNT, d);
    check(32'(d < 32'd16), 32'h1, "count cleared by trigger");
    rd(A_STATUS, d);
    check(32'(d[ST_TRG]), 32'h1, "trigger flag");
    // Count sibling trigger edges; each pulse stands three cycles, then rests
    start(32'(1 | (32'(SL_EXT) << CTRL_SLV)), 32'h0, 32'hffff);
    n = 2 + ($random(seed) & 3);
    repeat (n) begin
      @(posedge clk);
      trig_req <= 1'b1;
      @(posedge clk);
      trig_req <= 1'b0;
      repeat (6) @(posedge clk);
    end
    rd(A_CNT, d);
    check(d, 32'(n), "trigger edges counted");
    $display("test trigger done");
    // One-pulse: the first update stops the counter at zero
    start(32'(1 | (1 << CTRL_OPM)), 32'h0, 32'h5);
    repeat (20) @(posedge clk);
    rd(A_CTRL, d);
    check(32'(d[CTRL_EN]), 32'h0, "one-pulse stop");
    rd(A_CNT, d);
    check(d, 32'h0, "one-pulse rests at zero");
    $display("test one-pulse done");
    // Hall mode: xor of three inputs feeds the channel 0 capture
    wr(A_CHMODE, 32'h0);
    wr(A_CTRL, 32'(1 << CTRL_HALL));
    wr(A_STATUS, 32'h3f);
    rd(A_STATUS, d);
    check(32'(d[ST_CC]), 32'h0, "hall idle");
    repeat (2) begin
      @(posedge clk);
      pins_r[0] <= ~pins_r[0];
      repeat (3) @(posedge clk);
    end
    rd(A_STATUS, d);
    check(32'(d[ST_CC]), 32'h1, "hall edge captured");
    $display("test hall done");
    // Reset in mid-run brings registers and outputs back to rest
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(A_CTRL, d);
    check(d, 32'h0, "ctrl after reset");
    check(32'({irq, dma_req, trig_out, ch_out}), 32'h0, "outputs after reset");
    rd(A_ARR, d);
    check(d, RST_ARR, "arr after reset");
    $display("test reset done");
    conclude();
  end
endmodule : testbench
